//--- dv/comparator_bank.sv
// =============================================================
// Threshold comparators at the block's inputs
// =============================================================
module comparator_bank
   import trig_qual_pkg::*;
#(
   parameter int DLY = 2
) (
   input  wire thresh_s     thr,
   input  wire logic [31:0] ana,
   output logic             a_above,
   output logic             b_above,
   output logic             c_above,
   output logic             d_above
);
   timeunit 1ns;
   timeprecision 100ps;
   // The lag lands edges between clock edges, as real pins would.
   assign #DLY a_above = ana[7:0] > thr.chan_a;
   assign #DLY b_above = ana[15:8] > thr.chan_b;
   assign #DLY c_above = ana[23:16] > thr.aux_c;
   assign #DLY d_above = ana[31:24] > thr.aux_d;
endmodule // comparator_bank

//--- dv/trigger_qualifier_logic_test.sv
module trigger_qualifier_logic_test
   import trig_qual_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, wr, rd, cha, chb, auxc, auxd, slow_rate, trig_out;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, ana, thr_w, d;
   thresh_s     thresholds;
   int          failures, n_compared;
   int          tot = 0;

   always #2.5 clk = ~clk;

   trigger_qualifier_logic #(.SLOW_CYC(50)) uut (.clk(clk), .rst_n(rst_n),
      .channel_a_input(cha), .channel_b_input(chb), .aux_c_input(auxc),
      .aux_d_input(auxd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .thresholds(thresholds), .trig_out(trig_out),
      .slow_rate(slow_rate));

   comparator_bank pb (.thr(thresholds), .ana(ana), .a_above(cha),
      .b_above(chb), .c_above(auxc), .d_above(auxd));

   always @(posedge clk) if (trig_out === 1'b1) tot <= tot + 1;

   // =============================================================
   // Compare and bus tasks
   // =============================================================
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      chk_val(32'(got), 32'(exp));
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask

   // Drives the pins to a level pattern, then counts pulses for cyc cycles.
   task automatic step(input logic [3:0] p, input int cyc, input int exp);
      int t0;
      t0 = tot;
      for (int i = 0; i < 4; i++) begin
         ana[8*i +: 8] <= p[i] ? thr_w[8*i +: 8] + 8'h08
                               : thr_w[8*i +: 8] - 8'h08;
      end
      repeat (cyc) @(posedge clk);
      chk_cnt(tot - t0, exp);
   endtask

   task automatic print_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // =============================================================
   // Main sequence
   // =============================================================
   initial begin
      clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0;
      addr = 8'h00; wdata = 32'h0; ana = 32'h0;
      failures = 0; n_compared = 0;
      void'($urandom(32'h3553));
      for (int i = 0; i < 4; i++) thr_w[8*i +: 8] = 8'h10 + 8'($urandom % 224);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      wr_reg(ADDR_THRESH, thr_w);
      wr_reg(ADDR_HOLDOFF, 32'h2);
      chk_val(thresholds, thr_w);
      rd_reg(8'h3C, d);
      chk_val(d, 32'h0);
      $display("Test registers finished");
      wr_reg(ADDR_PAT_CFG, 32'h23);
      wr_reg(ADDR_CTRL, 32'h11);
      step(4'b0000, 20, 0);
      step(4'b0010, 20, 1);
      step(4'b0110, 20, 0);
      step(4'b0100, 20, 0);
      step(4'b0110, 20, 1);
      rd_reg(ADDR_STATUS, d);
      chk_val(d[3:0], 4'b0110);
      wr_reg(ADDR_PAT_CFG, 32'h123);
      wr_reg(ADDR_CTRL, 32'h11);
      step(4'b0111, 20, 1);
      step(4'b0110, 20, 0);
      $display("Test pattern finished");
      wr_reg(ADDR_PRES_CFG, 32'h23);
      wr_reg(ADDR_PRES_TIME, 32'd10);
      wr_reg(ADDR_CTRL, 32'h12);
      step(4'b0000, 20, 0);
      step(4'b0010, 5, 0);
      step(4'b0000, 20, 0);
      step(4'b0010, 30, 0);
      step(4'b0000, 20, 1);
      // Event holdoff is requested here but must stay out of effect.
      wr_reg(ADDR_PRES_CFG, 32'h123);
      wr_reg(ADDR_CTRL, 32'h1A);
      for (int k = 0; k < 2; k++) begin
         step(4'b0010, 5, 0);
         step(4'b0000, 20, 1);
      end
      step(4'b0010, 30, 0);
      step(4'b0000, 20, 0);
      $display("Test present finished");
      wr_reg(ADDR_STATE_CFG, 32'hC23);
      wr_reg(ADDR_CTRL, 32'h1B);
      step(4'b0010, 20, 0);
      step(4'b0110, 20, 1);
      step(4'b0010, 20, 0);
      step(4'b0110, 20, 1);
      step(4'b0100, 20, 0);
      step(4'b0000, 20, 0);
      step(4'b0100, 20, 0);
      wr_reg(ADDR_STATE_CFG, 32'hD23);
      wr_reg(ADDR_CTRL, 32'h1B);
      step(4'b0000, 20, 0);
      step(4'b0100, 20, 1);
      $display("Test state finished");
      wr_reg(ADDR_TDLY_CFG, 32'h2C);
      wr_reg(ADDR_TDLY_TIME, 32'd12);
      wr_reg(ADDR_CTRL, 32'h14);
      step(4'b0000, 20, 0);
      step(4'b0001, 3, 0);
      step(4'b0011, 3, 0);
      step(4'b0001, 10, 0);
      step(4'b0011, 20, 1);
      step(4'b0001, 20, 0);
      step(4'b0011, 20, 0);
      wr_reg(ADDR_TDLY_CFG, 32'h24);
      wr_reg(ADDR_CTRL, 32'h14);
      step(4'b0000, 20, 0);
      step(4'b0001, 40, 0);
      // A second arming-source edge, long after the wait, must not fire.
      step(4'b0000, 5, 0);
      step(4'b0001, 20, 0);
      $display("Test time delay finished");
      wr_reg(ADDR_EDLY_CFG, 32'h2C);
      wr_reg(ADDR_EDLY_CNT, 32'd3);
      wr_reg(ADDR_CTRL, 32'h15);
      step(4'b0000, 10, 0);
      step(4'b0010, 10, 0);
      step(4'b0000, 10, 0);
      step(4'b0001, 10, 0);
      for (int k = 0; k < 3; k++) begin
         step(4'b0011, 10, 0);
         step(4'b0001, 10, 0);
      end
      step(4'b0011, 20, 1);
      $display("Test event delay finished");
      wr_reg(ADDR_EDGE_CFG, 32'h21);
      wr_reg(ADDR_CTRL, 32'h18);
      // The source must start low, or the first rising edge never comes.
      step(4'b0000, 20, 0);
      for (int k = 0; k < 6; k++) begin
         step(4'b0010, 20, int'(k % 3 == 0));
         step(4'b0000, 20, 0);
      end
      $display("Test event holdoff finished");
      wr_reg(ADDR_CTRL, 32'h11);
      step(4'b0010, 20, 0);
      step(4'b0000, 80, 1);
      chk_val(32'(slow_rate), 32'h1);
      rd_reg(ADDR_STATUS, d);
      chk_val({d[31:16], d[6], d[3:0]}, {16'(tot), 1'b1, 4'b0000});
      $display("Test status finished");
      print_verdict;
   end

   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      print_verdict;
   end
endmodule // trigger_qualifier_logic_test

//--- hw/trig_qual_pkg.sv
package trig_qual_pkg;

   // =====================================================================
   // Register map (byte addresses on the plain register port)
   // =====================================================================
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_THRESH    = 8'h04;
   localparam logic [7:0] ADDR_EDGE_CFG  = 8'h08;
   localparam logic [7:0] ADDR_PAT_CFG   = 8'h0C;
   localparam logic [7:0] ADDR_PRES_CFG  = 8'h10;
   localparam logic [7:0] ADDR_PRES_TIME = 8'h14;
   localparam logic [7:0] ADDR_STATE_CFG = 8'h18;
   localparam logic [7:0] ADDR_TDLY_CFG  = 8'h1C;
   localparam logic [7:0] ADDR_TDLY_TIME = 8'h20;
   localparam logic [7:0] ADDR_EDLY_CFG  = 8'h24;
   localparam logic [7:0] ADDR_EDLY_CNT  = 8'h28;
   localparam logic [7:0] ADDR_HOLDOFF   = 8'h2C;
   localparam logic [7:0] ADDR_STATUS    = 8'h30;

   // =====================================================================
   // Field positions
   // =====================================================================
   localparam int CTRL_HOLD_EV_BIT = 3;
   localparam int CTRL_ENABLE_BIT  = 4;
   localparam int PAT_LEVEL_LSB    = 4;
   localparam int CFG_FLAG_BIT     = 8;
   localparam int ST_SRC_LSB       = 9;
   localparam int ST_POS_BIT       = 11;
   localparam int EDGE_SLOPE_LSB   = 4;
   localparam int DLY_ARM_POS_BIT  = 2;
   localparam int DLY_TRG_SRC_LSB  = 3;
   localparam int DLY_TRG_POS_BIT  = 5;

   // =====================================================================
   // Timing at a 200 MHz clock
   // =====================================================================
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned PRES_MIN_NS     = 10;
   localparam int unsigned RECOG_NS        = 1;
   localparam int unsigned TDLY_MIN_NS     = 20;
   localparam int unsigned HOLDOFF_MIN_NS  = 70;
   localparam int unsigned SLOW_RATE_HZ    = 20;
   localparam int unsigned PRES_MIN_CYC    = (PRES_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RECOG_CYC       = (RECOG_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TDLY_MIN_CYC    = (TDLY_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned HOLDOFF_MIN_CYC =
      (HOLDOFF_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SLOW_RATE_CYC   = CLK_MHZ * 1000000 / SLOW_RATE_HZ;

   // =====================================================================
   // Types
   // =====================================================================
   typedef enum logic [2:0] {
      MODE_EDGE, MODE_PATTERN, MODE_PRESENT, MODE_STATE, MODE_TDLY, MODE_EDLY
   } mode_e;

   typedef struct packed {
      logic [7:0] aux_d;
      logic [7:0] aux_c;
      logic [7:0] chan_b;
      logic [7:0] chan_a;
   } thresh_s;

   // Care bit set means the input qualifies; level 1 means above threshold.
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] care;
   } pat_s;

   typedef struct packed {
      logic       trg_pos;
      logic [1:0] trg_src;
      logic       arm_pos;
      logic [1:0] arm_src;
   } dly_s;

   typedef struct packed {
      mode_e       mode;
      logic        hold_ev;
      logic        enable;
      thresh_s     thr;
      logic [1:0]  ed_src;
      logic [3:0]  ed_slope;
      pat_s        pat_cfg;
      logic        pat_exit;
      pat_s        pres_cfg;
      logic        pres_short;
      logic [31:0] pres_time;
      pat_s        st_cfg;
      logic [1:0]  st_src;
      logic        st_pos;
      logic        st_not;
      dly_s        tdly;
      logic [31:0] tdly_time;
      dly_s        edly;
      logic [31:0] edly_count;
      logic [31:0] holdoff;
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic [3:0]  prev;
      logic        match_prev;
      logic [31:0] dur;
      logic        armed;
      logic [31:0] wait_cnt;
      logic [31:0] ev_cnt;
      logic [31:0] ho_cnt;
      logic [31:0] div_cnt;
      logic [31:0] rate_cnt;
      logic        slow;
      logic        trig;
      logic [15:0] trig_total;
      logic [31:0] rdata;
   } state_s;

   localparam state_s STATE_RST = state_s'('0);

endpackage

//--- hw/trigger_qualifier_logic.sv
// What this block does
// - Each input required low, high, or ignored.
// - Entered mode triggers when pattern becomes true.
// - Exited mode triggers when true pattern breaks.
// - Longer-than: trigger on break after minimum time.
// - Longer-than: early break gives no trigger.
// - Shorter-than: trigger on break before time.
// - Present modes allow only time-based holdoff.
// - State mode: edge qualified by other three.
// - State mode allows only time-based holdoff.
// - Time delay: arm, wait delay, then trigger.
// - Trigger edge source differs from arming source.
// - Event delay: arm, then count edges, trigger.
// - Counted and triggering edges share source, polarity.
// - Per-input thresholds shared by every mode.
// - Each mode keeps its own slope, pattern settings.
// - Flag accepted trigger rate below twenty hertz.
// - Event holdoff divides accepted triggers by N+1.
module trigger_qualifier_logic
   import trig_qual_pkg::*;
#(
   parameter int unsigned SLOW_CYC = SLOW_RATE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        channel_a_input,
   input  wire logic        channel_b_input,
   input  wire logic        aux_c_input,
   input  wire logic        aux_d_input,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output thresh_s          thresholds,
   output logic             trig_out,
   output logic             slow_rate
);

   // =====================================================================
   // Helpers
   // =====================================================================
   function automatic logic pat_match(pat_s p, logic [3:0] v);
      return &(~p.care | ~(v ^ p.level));
   endfunction

   function automatic logic edge_hit(logic [3:0] cur, logic [3:0] prv,
                                     logic [1:0] src, logic pos);
      return pos ? (cur[src] & ~prv[src]) : (~cur[src] & prv[src]);
   endfunction

   function automatic logic [31:0] at_least(logic [31:0] v,
                                            logic [31:0] lo);
      return (v < lo) ? lo : v;
   endfunction

   localparam logic [31:0] PRES_MIN = 32'(PRES_MIN_CYC);
   localparam logic [31:0] RECOG    = 32'(RECOG_CYC);
   localparam logic [31:0] TDLY_MIN = 32'(TDLY_MIN_CYC);
   localparam logic [31:0] HO_MIN   = 32'(HOLDOFF_MIN_CYC);
   localparam logic [31:0] SLOW_LIM = 32'(SLOW_CYC - 1);

   state_s s_r;
   state_s s_nxt;

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb begin
      logic [3:0]  cur;
      logic [3:0]  prv;
      logic        m;
      logic        hit;
      logic        ev_ok;
      logic        arm_e;
      logic        trg_e;
      pat_s        st_p;
      cur   = s_r.sync2;
      prv   = s_r.prev;
      m     = 1'b0;
      hit   = 1'b0;
      arm_e = 1'b0;
      trg_e = 1'b0;
      st_p  = s_r.st_cfg;
      ev_ok = s_r.hold_ev && s_r.mode != MODE_PRESENT &&
              s_r.mode != MODE_STATE;
      s_nxt = s_r;
      s_nxt.trig  = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.sync1 = {aux_d_input, aux_c_input,
                     channel_b_input, channel_a_input};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;

      case (s_r.mode)
         MODE_EDGE: begin
            hit = edge_hit(cur, prv, s_r.ed_src,
                           s_r.ed_slope[s_r.ed_src]);
         end
         MODE_PATTERN: begin
            m = pat_match(s_r.pat_cfg, cur);
            hit = s_r.pat_exit ? (~m & s_r.match_prev)
                               : (m & ~s_r.match_prev);
            s_nxt.match_prev = m;
         end
         MODE_PRESENT: begin
            m = pat_match(s_r.pres_cfg, cur);
            s_nxt.dur = m ? ((s_r.dur == '1) ? s_r.dur : s_r.dur + 32'h1)
                          : 32'h0;
            if (~m & s_r.match_prev) begin
               if (s_r.pres_short)
                  hit = (s_r.dur >= RECOG) &&
                        (s_r.dur < at_least(s_r.pres_time, PRES_MIN));
               else
                  hit = s_r.dur >= at_least(s_r.pres_time, PRES_MIN);
            end
            s_nxt.match_prev = m;
         end
         MODE_STATE: begin
            st_p.care = s_r.st_cfg.care & ~(4'h1 << s_r.st_src);
            m = pat_match(st_p, cur);
            hit = edge_hit(cur, prv, s_r.st_src, s_r.st_pos) &
                  (m ^ s_r.st_not);
         end
         MODE_TDLY: begin
            arm_e = edge_hit(cur, prv, s_r.tdly.arm_src, s_r.tdly.arm_pos);
            trg_e = edge_hit(cur, prv, s_r.tdly.trg_src, s_r.tdly.trg_pos);
            if (!s_r.armed) begin
               if (arm_e) begin
                  s_nxt.armed    = 1'b1;
                  s_nxt.wait_cnt = 32'h1;
               end
            end else begin
               if (s_r.wait_cnt != '1)
                  s_nxt.wait_cnt = s_r.wait_cnt + 32'h1;
               if (trg_e && s_r.tdly.trg_src != s_r.tdly.arm_src &&
                   s_r.wait_cnt >= at_least(s_r.tdly_time, TDLY_MIN)) begin
                  hit = 1'b1;
                  s_nxt.armed = 1'b0;
               end
            end
         end
         MODE_EDLY: begin
            arm_e = edge_hit(cur, prv, s_r.edly.arm_src, s_r.edly.arm_pos);
            trg_e = edge_hit(cur, prv, s_r.edly.trg_src, s_r.edly.trg_pos);
            if (!s_r.armed) begin
               if (arm_e) begin
                  s_nxt.armed  = 1'b1;
                  s_nxt.ev_cnt = 32'h0;
               end
            end else if (trg_e && s_r.edly.trg_src != s_r.edly.arm_src) begin
               // Edges of the same source both count and finally fire; the firing edge is not counted.
               if (s_r.ev_cnt >= s_r.edly_count) begin
                  hit = 1'b1;
                  s_nxt.armed = 1'b0;
               end else begin
                  s_nxt.ev_cnt = s_r.ev_cnt + 32'h1;
               end
            end
         end
         default: hit = 1'b0;
      endcase

      hit = hit & s_r.enable;

      // =====================================================================
      // Holdoff and accepted-trigger path
      // =====================================================================
      // Count holdoff is forced off in modes whose trigger is a duration or
      // a qualified clock edge, so a stale setting cannot leak into them.
      if (s_r.ho_cnt != 32'h0) begin
         s_nxt.ho_cnt = s_r.ho_cnt - 32'h1;
      end else if (hit) begin
         if (ev_ok) begin
            if (s_r.div_cnt == 32'h0) begin
               s_nxt.trig    = 1'b1;
               s_nxt.div_cnt = s_r.holdoff;
            end else begin
               s_nxt.div_cnt = s_r.div_cnt - 32'h1;
            end
         end else begin
            s_nxt.trig   = 1'b1;
            s_nxt.ho_cnt = at_least(s_r.holdoff, HO_MIN);
         end
      end

      if (s_nxt.trig) begin
         s_nxt.trig_total = s_r.trig_total + 16'h1;
         s_nxt.rate_cnt   = 32'h0;
         s_nxt.slow       = 1'b0;
      end else if (s_r.rate_cnt >= SLOW_LIM) begin
         s_nxt.slow = 1'b1;
      end else begin
         s_nxt.rate_cnt = s_r.rate_cnt + 32'h1;
      end

      // =====================================================================
      // Register port
      // =====================================================================
      if (wr) begin
         case (addr)
            ADDR_CTRL: begin
               s_nxt.mode    = mode_e'(wdata[2:0]);
               s_nxt.hold_ev = wdata[CTRL_HOLD_EV_BIT];
               s_nxt.enable  = wdata[CTRL_ENABLE_BIT];
               // A CTRL write restarts every sequence except a running holdoff count (ho_cnt) from idle.
               s_nxt.armed      = 1'b0;
               s_nxt.dur        = 32'h0;
               s_nxt.match_prev = 1'b0;
               s_nxt.div_cnt    = 32'h0;
            end
            ADDR_THRESH:    s_nxt.thr = thresh_s'(wdata);
            ADDR_EDGE_CFG: begin
               s_nxt.ed_src   = wdata[1:0];
               s_nxt.ed_slope = wdata[EDGE_SLOPE_LSB +: 4];
            end
            ADDR_PAT_CFG: begin
               s_nxt.pat_cfg  = pat_s'(wdata[7:0]);
               s_nxt.pat_exit = wdata[CFG_FLAG_BIT];
            end
            ADDR_PRES_CFG: begin
               s_nxt.pres_cfg   = pat_s'(wdata[7:0]);
               s_nxt.pres_short = wdata[CFG_FLAG_BIT];
            end
            ADDR_PRES_TIME: s_nxt.pres_time = wdata;
            ADDR_STATE_CFG: begin
               s_nxt.st_cfg = pat_s'(wdata[7:0]);
               s_nxt.st_not = wdata[CFG_FLAG_BIT];
               s_nxt.st_src = wdata[ST_SRC_LSB +: 2];
               s_nxt.st_pos = wdata[ST_POS_BIT];
            end
            ADDR_TDLY_CFG:  s_nxt.tdly = dly_s'(wdata[5:0]);
            ADDR_TDLY_TIME: s_nxt.tdly_time = wdata;
            ADDR_EDLY_CFG:  s_nxt.edly = dly_s'(wdata[5:0]);
            ADDR_EDLY_CNT:  s_nxt.edly_count = wdata;
            ADDR_HOLDOFF:   s_nxt.holdoff = wdata;
            default: ;
         endcase
      end

      if (rd) begin
         case (addr)
            ADDR_CTRL:      s_nxt.rdata = {27'h0, s_r.enable, s_r.hold_ev,
                                           3'(s_r.mode)};
            ADDR_THRESH:    s_nxt.rdata = 32'(s_r.thr);
            ADDR_EDGE_CFG:  s_nxt.rdata = {24'h0, s_r.ed_slope, 2'h0,
                                           s_r.ed_src};
            ADDR_PAT_CFG:   s_nxt.rdata = {23'h0, s_r.pat_exit, s_r.pat_cfg};
            ADDR_PRES_CFG:  s_nxt.rdata = {23'h0, s_r.pres_short,
                                           s_r.pres_cfg};
            ADDR_PRES_TIME: s_nxt.rdata = s_r.pres_time;
            ADDR_STATE_CFG: s_nxt.rdata = {20'h0, s_r.st_pos, s_r.st_src,
                                           s_r.st_not, s_r.st_cfg};
            ADDR_TDLY_CFG:  s_nxt.rdata = {26'h0, s_r.tdly};
            ADDR_TDLY_TIME: s_nxt.rdata = s_r.tdly_time;
            ADDR_EDLY_CFG:  s_nxt.rdata = {26'h0, s_r.edly};
            ADDR_EDLY_CNT:  s_nxt.rdata = s_r.edly_count;
            ADDR_HOLDOFF:   s_nxt.rdata = s_r.holdoff;
            ADDR_STATUS:    s_nxt.rdata = {s_r.trig_total, 9'h0, s_r.slow,
                                           s_r.armed, s_r.match_prev,
                                           s_r.sync2};
            default:        s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         s_r <= STATE_RST;
      else
         s_r <= s_nxt;
   end

   assign rdata      = s_r.rdata;
   assign thresholds = s_r.thr;
   assign trig_out   = s_r.trig;
   assign slow_rate  = s_r.slow;

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_sync_two_stage: assert property (
      ##2 s_r.sync2 == $past({aux_d_input, aux_c_input,
                              channel_b_input, channel_a_input}, 2))
      else $error("input not delayed by two stages");

   a_entered_edge: assert property (
      s_r.trig && $past(s_r.mode) == MODE_PATTERN && !$past(s_r.pat_exit)
      |-> pat_match($past(s_r.pat_cfg), $past(s_r.sync2)) &&
          !$past(s_r.match_prev))
      else $error("entered trigger without completing pattern");

   a_exited_edge: assert property (
      s_r.trig && $past(s_r.mode) == MODE_PATTERN && $past(s_r.pat_exit)
      |-> !pat_match($past(s_r.pat_cfg), $past(s_r.sync2)) &&
          $past(s_r.match_prev))
      else $error("exited trigger without a broken pattern");

   a_longer_time: assert property (
      s_r.trig && $past(s_r.mode) == MODE_PRESENT && !$past(s_r.pres_short)
      |-> $past(s_r.dur) >= at_least($past(s_r.pres_time), PRES_MIN))
      else $error("longer-than trigger came too early");

   a_shorter_time: assert property (
      s_r.trig && $past(s_r.mode) == MODE_PRESENT && $past(s_r.pres_short)
      |-> $past(s_r.dur) >= RECOG &&
          $past(s_r.dur) < at_least($past(s_r.pres_time), PRES_MIN))
      else $error("shorter-than trigger outside its window");

   a_time_holdoff: assert property (
      s_r.trig && ($past(s_r.mode) == MODE_PRESENT ||
                   $past(s_r.mode) == MODE_STATE)
      |-> s_r.ho_cnt >= HO_MIN)
      else $error("count holdoff used in a time-only mode");

   a_holdoff_quiet: assert property (
      s_r.trig && s_r.ho_cnt >= HO_MIN |=> !s_r.trig [*8])
      else $error("trigger accepted inside holdoff");

   a_divide_n: assert property (
      s_r.trig && $past(s_r.hold_ev) && $past(s_r.mode) == MODE_EDGE
      |-> $past(s_r.div_cnt) == 32'h0 && s_r.div_cnt == $past(s_r.holdoff))
      else $error("count holdoff did not divide by N+1");

   a_tdly_wait: assert property (
      s_r.trig && $past(s_r.mode) == MODE_TDLY
      |-> $past(s_r.wait_cnt) >= at_least($past(s_r.tdly_time), TDLY_MIN) &&
          $past(s_r.tdly.trg_src) != $past(s_r.tdly.arm_src))
      else $error("delayed trigger before wait or from arming source");

   a_edly_count: assert property (
      s_r.trig && $past(s_r.mode) == MODE_EDLY
      |-> $past(s_r.ev_cnt) >= $past(s_r.edly_count) && !s_r.armed)
      else $error("event delay fired before count reached");

   a_slow_clear: assert property (s_r.trig |-> !s_r.slow)
      else $error("slow flag stayed set on an accepted trigger");

endmodule // trigger_qualifier_logic
